// file: verilog/rxpeq_regs.sv
// Receive-port register bank: equalizer control and status, error interrupt enables and
// latches, remote self-test flag and GPIO pull-down control.
// Assumes a byte register port on clk_sys; lock and self-test levels arrive asynchronously,
// error pulses come from logic on clk_sys.
`timescale 1ns/1ps
module rxpeq_regs
  import rxpeq_pkg::*;
#(
  parameter int RELOCK_BASE = RELOCK_BASE_CYC,
  parameter int NUM_GPIO    = GPIO_COUNT
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  input  wire logic                lock_detect_in,
  input  wire logic                remote_selftest_in,
  input  wire logic                link_coding_err,
  input  wire logic                ctrl_chan_seq_err,
  input  wire logic                ctrl_chan_crc_err,
  input  wire logic [NUM_GPIO-1:0] gpio_output_mode,
  output logic      [NUM_GPIO-1:0] gpio_pulldown_en,
  output logic      [5:0]          eq_setting,
  output logic                     rx_lock,
  output logic                     port_irq
);

  logic [7:0]          pulldown_dis_r;
  logic [7:0]          debug_rw_r;
  logic [2:0]          eq_relock_wait_r;
  logic                eq_first_lock_mode_r;
  logic                eq_adapt_restart_r;
  logic                eq_floor_enable_r;
  logic [2:0]          manual_eq_upper_r;
  logic                lock_needs_eq_done_r;
  logic [2:0]          manual_eq_lower_r;
  logic                eq_adapt_disable_r;
  logic [3:0]          eq_ceiling_r;
  logic [3:0]          eq_floor_setting_r;
  logic [2:0]          irq_en_hi_r;
  logic [7:0]          irq_en_lo_r;
  logic                coding_err_r;
  logic                seq_err_r;
  logic                crc_err_r;
  logic [1:0]          lock_sync_r;
  logic [1:0]          selftest_sync_r;
  logic [5:0]          eq_now;
  logic                adapt_done;
  logic                wr_en;
  logic                rd_en;
  logic                clr_sts1;
  logic                clr_sts2;
  logic [7:0]          rd_mux;

  assign wr_en    = ce && reg_wr;
  assign rd_en    = ce && reg_rd;
  assign clr_sts1 = rd_en && (reg_addr == ADDR_PORT_STS1);
  assign clr_sts2 = rd_en && (reg_addr == ADDR_PORT_STS2);

  // Two-stage synchronisers for the analog lock detector and the remote status level
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lock_sync_r     <= 2'b00;
      selftest_sync_r <= 2'b00;
    end else if (ce) begin
      lock_sync_r     <= {lock_sync_r[0], lock_detect_in};
      selftest_sync_r <= {selftest_sync_r[0], remote_selftest_in};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pulldown_dis_r <= 8'h00;
      debug_rw_r     <= 8'h00;
    end else if (wr_en) begin
      if (reg_addr == ADDR_PULLDOWN) begin
        pulldown_dis_r <= reg_wdata; // RULE2
      end
      if (reg_addr == ADDR_DEBUG) begin
        debug_rw_r <= reg_wdata & DBG_RW_MASK;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      eq_relock_wait_r     <= RELOCK_RESET; // RULE4
      eq_first_lock_mode_r <= 1'b0;
      eq_floor_enable_r    <= 1'b0;
      eq_adapt_restart_r   <= 1'b0;
    end else if (ce) begin
      // Self-clearing: holds for one cycle, long enough for the engine to see it
      eq_adapt_restart_r <= 1'b0; // RULE6
      if (reg_wr && reg_addr == ADDR_EQ_TEST) begin
        eq_relock_wait_r     <= reg_wdata[RELOCK_LSB +: 3];
        eq_first_lock_mode_r <= reg_wdata[FIRST_LOCK_BIT]; // RULE5
        eq_adapt_restart_r   <= reg_wdata[RESTART_BIT]; // RULE6
        eq_floor_enable_r    <= reg_wdata[FLOOR_EN_BIT]; // RULE7
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      manual_eq_upper_r    <= MAN_UPPER_RESET;
      lock_needs_eq_done_r <= 1'b0;
      manual_eq_lower_r    <= MAN_LOWER_RESET;
      eq_adapt_disable_r   <= 1'b0; // RULE11
      eq_ceiling_r         <= CEIL_RESET; // RULE9
      eq_floor_setting_r   <= FLOOR_RESET; // RULE8
    end else if (wr_en) begin
      if (reg_addr == ADDR_EQ_BYPASS) begin
        manual_eq_upper_r    <= reg_wdata[MAN_UPPER_LSB +: 3]; // RULE12
        lock_needs_eq_done_r <= reg_wdata[LOCK_MODE_BIT]; // RULE13
        manual_eq_lower_r    <= reg_wdata[MAN_LOWER_LSB +: 3]; // RULE12
        eq_adapt_disable_r   <= reg_wdata[BYPASS_BIT]; // RULE11
      end
      if (reg_addr == ADDR_EQ_LIMITS) begin
        eq_ceiling_r       <= reg_wdata[CEIL_LSB +: 4]; // RULE9
        eq_floor_setting_r <= reg_wdata[3:0]; // RULE8
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_en_hi_r <= 3'h0;
      irq_en_lo_r <= 8'h00;
    end else if (wr_en) begin
      if (reg_addr == ADDR_IRQ_EN_HI) begin
        irq_en_hi_r <= reg_wdata[2:0]; // RULE14 RULE15 RULE16
      end
      if (reg_addr == ADDR_IRQ_EN_LO) begin
        irq_en_lo_r <= reg_wdata;
      end
    end
  end

  // Latches run regardless of enables; a new event in the clearing read cycle wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      coding_err_r <= 1'b0;
      seq_err_r    <= 1'b0;
      crc_err_r    <= 1'b0;
    end else if (ce) begin
      coding_err_r <= link_coding_err || (coding_err_r && !clr_sts2); // RULE17
      seq_err_r    <= ctrl_chan_seq_err || (seq_err_r && !clr_sts1); // RULE17
      crc_err_r    <= ctrl_chan_crc_err || (crc_err_r && !clr_sts1); // RULE17
    end
  end

  rxpeq_adapt #(
    .RELOCK_BASE (RELOCK_BASE)
  ) u_adapt (
    .clk_sys         (clk_sys),
    .rst             (rst),
    .ce              (ce),
    .lock_in         (lock_sync_r[1]),
    .restart         (eq_adapt_restart_r),
    .relock_code     (eq_relock_wait_r),
    .first_lock_mode (eq_first_lock_mode_r),
    .floor_enable    (eq_floor_enable_r),
    .floor_setting   (eq_floor_setting_r),
    .ceiling         (eq_ceiling_r),
    .adapt_disable   (eq_adapt_disable_r),
    .manual_setting  ({manual_eq_upper_r, manual_eq_lower_r}),
    .eq_setting      (eq_now),
    .adapt_done      (adapt_done)
  );

  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      ADDR_PULLDOWN:   rd_mux = pulldown_dis_r;
      ADDR_DEBUG: begin
        rd_mux                   = debug_rw_r;
        rd_mux[DBG_SELFTEST_BIT] = selftest_sync_r[1]; // RULE3
      end
      ADDR_EQ_TEST:    rd_mux = {eq_relock_wait_r, eq_first_lock_mode_r, eq_adapt_restart_r,
                                 eq_floor_enable_r, 2'b00};
      ADDR_EQ_STATUS:  rd_mux = {2'b00, eq_now}; // RULE10
      ADDR_EQ_BYPASS:  rd_mux = {manual_eq_upper_r, lock_needs_eq_done_r, manual_eq_lower_r,
                                 eq_adapt_disable_r};
      ADDR_EQ_LIMITS:  rd_mux = {eq_ceiling_r, eq_floor_setting_r};
      ADDR_IRQ_EN_HI:  rd_mux = {5'h00, irq_en_hi_r};
      ADDR_IRQ_EN_LO:  rd_mux = irq_en_lo_r;
      ADDR_IRQ_STS_HI: rd_mux = {5'h00, coding_err_r, seq_err_r, crc_err_r};
      ADDR_PORT_STS1:  rd_mux = {6'h00, seq_err_r, crc_err_r};
      ADDR_PORT_STS2:  rd_mux = {7'h00, coding_err_r};
      default:         rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (rd_en) begin
      reg_rdata <= rd_mux;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gpio_pulldown_en <= '1;
      eq_setting       <= 6'h00;
      rx_lock          <= 1'b0;
      port_irq         <= 1'b0;
    end else if (ce) begin
      gpio_pulldown_en <= ~gpio_output_mode & ~pulldown_dis_r[NUM_GPIO-1:0]; // RULE1 RULE2
      eq_setting       <= eq_now;
      rx_lock          <= lock_sync_r[1] && (!lock_needs_eq_done_r || adapt_done); // RULE13
      port_irq         <= (coding_err_r && irq_en_hi_r[IRQ_ENC_BIT])   // RULE14 RULE18
                       || (seq_err_r && irq_en_hi_r[IRQ_SEQ_BIT])      // RULE15
                       || (crc_err_r && irq_en_hi_r[IRQ_CRC_BIT]);     // RULE16
    end
  end

endmodule : rxpeq_regs

// file: verilog/rxpeq_pkg.sv
// Constants, register map and field layout for one receive port's equalizer and interrupt registers.
// Assumes a single core clock at 100 MHz and byte-wide register accesses by 8-bit offset.
// What this block does
// [RULE1] Pull-down on whenever pin is not output and its disable bit is clear
// [RULE2] Disable bits 4..0 map to pins 4..0
// [RULE3] Bit 5 reports remote serializer self-test active
// [RULE4] Relock wait code 7:5, reset 4
// [RULE5] First-lock mode restarts adaptation from zero
// [RULE6] Restart bit restarts adaptation, then self-clears
// [RULE7] Floor enable starts adaptation at floor
// [RULE8] Floor value 3:0, reset 8, start setting
// [RULE9] Ceiling 7:4, reset F, caps adaptation
// [RULE10] Status shows two 3-bit setting fields
// [RULE11] Bypass bit 0 disables adaptation
// [RULE12] Bypassed setting comes from manual fields
// [RULE13] Lock mode makes lock wait for adaptation
// [RULE14] Enable bit 2: link coding error interrupt
// [RULE15] Enable bit 1: control channel sequence error
// [RULE16] Enable bit 0: control channel CRC error
// [RULE17] Reading status register clears latched conditions
// [RULE18] Interrupt while any enabled condition latched
// [RULE19] Timeout without lock steps up, capped; the code wraps back to the start point at the ceiling
package rxpeq_pkg;

  localparam logic [7:0] ADDR_PULLDOWN    = 8'hBE;
  localparam logic [7:0] ADDR_DEBUG       = 8'hD0;
  localparam logic [7:0] ADDR_EQ_TEST     = 8'hD2;
  localparam logic [7:0] ADDR_EQ_STATUS   = 8'hD3;
  localparam logic [7:0] ADDR_EQ_BYPASS   = 8'hD4;
  localparam logic [7:0] ADDR_EQ_LIMITS   = 8'hD5;
  localparam logic [7:0] ADDR_IRQ_EN_HI   = 8'hD8;
  localparam logic [7:0] ADDR_IRQ_EN_LO   = 8'hD9;
  localparam logic [7:0] ADDR_IRQ_STS_HI  = 8'hDA;
  localparam logic [7:0] ADDR_PORT_STS1   = 8'hDC;
  localparam logic [7:0] ADDR_PORT_STS2   = 8'hDD;

  localparam int         GPIO_COUNT       = 5;
  localparam int         DBG_SELFTEST_BIT = 5;
  // Bit 7 and the self-test flag are read-only; the rest is plain storage
  localparam logic [7:0] DBG_RW_MASK      = ~8'hA0;

  localparam int         RELOCK_LSB       = 5;
  localparam int         FIRST_LOCK_BIT   = 4;
  localparam int         RESTART_BIT      = 3;
  localparam int         FLOOR_EN_BIT     = 2;
  localparam logic [2:0] RELOCK_RESET     = 3'h4;

  localparam int         MAN_UPPER_LSB    = 5;
  localparam int         LOCK_MODE_BIT    = 4;
  localparam int         MAN_LOWER_LSB    = 1;
  localparam int         BYPASS_BIT       = 0;
  localparam logic [2:0] MAN_UPPER_RESET  = 3'h3;
  localparam logic [2:0] MAN_LOWER_RESET  = 3'h0;

  localparam int         CEIL_LSB         = 4;
  localparam logic [3:0] CEIL_RESET       = 4'hF;
  localparam logic [3:0] FLOOR_RESET      = 4'h8;

  localparam int         IRQ_ENC_BIT      = 2;
  localparam int         IRQ_SEQ_BIT      = 1;
  localparam int         IRQ_CRC_BIT      = 0;
  localparam int         STS1_SEQ_BIT     = 1;
  localparam int         STS1_CRC_BIT     = 0;
  localparam int         STS2_ENC_BIT     = 0;

  // Shortest relock wait; the longer codes double it per step
  localparam int         CLK_PERIOD_NS    = 10;
  localparam int         RELOCK_BASE_NS   = 164000;
  localparam int         RELOCK_BASE_CYC  = (RELOCK_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         TIMER_W          = 24;

  typedef enum logic [1:0] {
    RXPEQ_SEARCH = 2'b00,
    RXPEQ_LOCKED = 2'b01,
    RXPEQ_BYPASS = 2'b10
  } rxpeq_state_t;

  function automatic logic [TIMER_W-1:0] relock_cycles(input logic [2:0] code, input int base);
    logic [TIMER_W-1:0] b;
    b = TIMER_W'(base);
    return b << code;
  endfunction : relock_cycles

endpackage : rxpeq_pkg

// file: verilog/rxpeq_adapt.sv
// Adaptive equalizer stepping engine: relock timer, start point, ceiling and bypass.
// Assumes lock_in is already synchronised to clk_sys and all controls are static between writes.
`timescale 1ns/1ps
module rxpeq_adapt
  import rxpeq_pkg::*;
#(
  parameter int RELOCK_BASE = RELOCK_BASE_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       lock_in,
  input  wire logic       restart,
  input  wire logic [2:0] relock_code,
  input  wire logic       first_lock_mode,
  input  wire logic       floor_enable,
  input  wire logic [3:0] floor_setting,
  input  wire logic [3:0] ceiling,
  input  wire logic       adapt_disable,
  input  wire logic [5:0] manual_setting,
  output logic      [5:0] eq_setting,
  output logic            adapt_done
);

  rxpeq_state_t       state_r;
  logic [3:0]         step_r;
  logic [TIMER_W-1:0] timer_r;
  logic               first_seen_r;
  logic [3:0]         start_val;
  logic               timeout;

  assign start_val = floor_enable ? floor_setting : 4'h0; // RULE7 RULE8
  assign timeout   = (timer_r >= relock_cycles(relock_code, RELOCK_BASE) - TIMER_W'(1)); // RULE4

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r      <= RXPEQ_SEARCH;
      step_r       <= 4'h0;
      timer_r      <= '0;
      first_seen_r <= 1'b0;
    end else if (ce) begin
      if (adapt_disable) begin
        state_r <= RXPEQ_BYPASS; // RULE11
        timer_r <= '0;
      end else if (restart || state_r == RXPEQ_BYPASS) begin
        state_r <= RXPEQ_SEARCH; // RULE6
        step_r  <= start_val;
        timer_r <= '0;
      end else begin
        unique case (state_r)
          RXPEQ_SEARCH: begin
            if (lock_in) begin
              timer_r      <= '0;
              first_seen_r <= 1'b1;
              if (first_lock_mode && !first_seen_r) begin
                step_r <= 4'h0; // RULE5
              end else begin
                state_r <= RXPEQ_LOCKED;
              end
            end else if (timeout) begin
              timer_r <= '0;
              // Wrap to the start point rather than sit at the ceiling forever
              step_r  <= (step_r >= ceiling) ? start_val : step_r + 4'h1; // RULE19 RULE9
            end else begin
              timer_r <= timer_r + TIMER_W'(1);
            end
          end
          RXPEQ_LOCKED: begin
            if (!lock_in) begin
              state_r <= RXPEQ_SEARCH;
              timer_r <= '0;
            end
          end
          RXPEQ_BYPASS: state_r <= RXPEQ_SEARCH;
          default:      state_r <= RXPEQ_SEARCH;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      eq_setting <= 6'h00;
      adapt_done <= 1'b0;
    end else if (ce) begin
      // Clamp so a floor above the ceiling, or a lowered ceiling, never overshoots
      eq_setting <= (state_r == RXPEQ_BYPASS) ? manual_setting
                  : {2'b00, (step_r > ceiling) ? ceiling : step_r}; // RULE12 RULE9
      adapt_done <= (state_r != RXPEQ_SEARCH);
    end
  end

endmodule : rxpeq_adapt

// file: testbench/rxpeq_monitor.sv
// Checker for the receive-port register bank, bound to the top module's ports.
// Assumes ce stays high while the mirrored equalizer control bytes are written.
`timescale 1ns/1ps
module rxpeq_monitor
  import rxpeq_pkg::*;
#(
  parameter int RELOCK_BASE = RELOCK_BASE_CYC,
  parameter int NUM_GPIO    = GPIO_COUNT
) (
  input wire logic                clk_sys,
  input wire logic                rst,
  input wire logic                ce,
  input wire logic [7:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  input wire logic                lock_detect_in,
  input wire logic                remote_selftest_in,
  input wire logic                link_coding_err,
  input wire logic                ctrl_chan_seq_err,
  input wire logic                ctrl_chan_crc_err,
  input wire logic [NUM_GPIO-1:0] gpio_output_mode,
  input wire logic [NUM_GPIO-1:0] gpio_pulldown_en,
  input wire logic [5:0]          eq_setting,
  input wire logic                rx_lock,
  input wire logic                port_irq
);
  logic [7:0] byp_r;
  logic [7:0] lim_r;
  logic       errs;
  assign errs = link_coding_err || ctrl_chan_seq_err || ctrl_chan_crc_err;
  // Shadow copies, since the checker cannot see the register bodies
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      byp_r <= 8'h60;
      lim_r <= 8'hF8;
    end else if (ce && reg_wr && reg_addr == ADDR_EQ_BYPASS) begin
      byp_r <= reg_wdata;
    end else if (ce && reg_wr && reg_addr == ADDR_EQ_LIMITS) begin
      lim_r <= reg_wdata;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_pulldown;
    ce |=> (gpio_pulldown_en & $past(gpio_output_mode)) == '0;
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down on an output pin");
  property p_status;
    ce && reg_rd && reg_addr == ADDR_EQ_STATUS && $stable(eq_setting) ##1 $stable(eq_setting)
      |-> reg_rdata == {2'b00, eq_setting};
  endproperty
  a_status: assert property (p_status) else $error("status byte differs from setting");
  property p_restart;
    ce && reg_wr && reg_addr == ADDR_EQ_TEST ##2 ce && reg_rd && reg_addr == ADDR_EQ_TEST
      |=> !reg_rdata[RESTART_BIT];
  endproperty
  a_restart: assert property (p_restart) else $error("restart bit did not clear");
  property p_irq_rise;
    $rose(port_irq) |-> $past(errs, 2) || $past(reg_wr, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without cause");
  property p_irq_fall;
    $fell(port_irq) && !$past(rst) |-> $past(reg_rd, 2) || $past(reg_wr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without access");
  property p_ceiling;
    !byp_r[BYPASS_BIT] && !$past(byp_r[BYPASS_BIT], 3) |-> eq_setting <= {2'b00, lim_r[7:4]};
  endproperty
  a_ceiling: assert property (p_ceiling) else $error("setting above ceiling");
  property p_bypass;
    byp_r[BYPASS_BIT] && $past(byp_r, 3) == byp_r |-> eq_setting == {byp_r[7:5], byp_r[3:1]};
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypassed setting not manual");
  property p_lock;
    $rose(rx_lock) |-> $past(lock_detect_in, 3);
  endproperty
  a_lock: assert property (p_lock) else $error("lock reported without detector");
  c_clear: cover property (ce && reg_rd && reg_addr == ADDR_PORT_STS1 && port_irq);
  c_lock: cover property ($rose(rx_lock));
  c_bypass: cover property (byp_r[BYPASS_BIT] && eq_setting != 6'h00);
endmodule : rxpeq_monitor

// file: testbench/rxpeq_ser_model.sv
// Far-side serializer stand-in: lock and self-test levels and error events.
// Assumes the bench commands it; levels arrive off the core clock edge.
`timescale 1ns/1ps
module rxpeq_ser_model (
  input  wire logic       clk_sys,
  input  wire logic       lock_cmd,
  input  wire logic       bist_cmd,
  input  wire logic [2:0] err_cmd,
  output wire logic       lock_level,
  output wire logic       selftest_level,
  output logic      [2:0] err_pulse = 3'h0
);
  // Cable levels are asynchronous to the core clock
  assign #3 lock_level = lock_cmd;
  assign #3 selftest_level = bist_cmd;
  always @(posedge clk_sys) err_pulse <= err_cmd;
endmodule : rxpeq_ser_model

// file: testbench/testbench.sv
// Self-checking bench for the receive-port register bank with a serializer stand-in.
// Assumes a shortened relock base so equalizer stepping shows in a short run.
`timescale 1ns/1ps
module testbench;
  import rxpeq_pkg::*;
  localparam int BASE = 8;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       lock_cmd = 1'b0;
  logic       bist_cmd = 1'b0;
  logic [2:0] err_cmd = 3'h0;
  logic       lock_level;
  logic       selftest_level;
  logic [2:0] err_pulse;
  logic [4:0] gpio_output_mode = 5'h00;
  logic [4:0] gpio_pulldown_en;
  logic [5:0] eq_setting;
  logic       rx_lock;
  logic       port_irq;
  int         mismatches = 0;
  int         checked = 0;
  int         cycles = 0;
  logic [7:0] rv;
  rxpeq_ser_model u_ser (.clk_sys(clk_sys), .lock_cmd(lock_cmd), .bist_cmd(bist_cmd), .err_cmd(err_cmd),
    .lock_level(lock_level), .selftest_level(selftest_level), .err_pulse(err_pulse));
  rxpeq_regs #(.RELOCK_BASE(BASE)) u_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .lock_detect_in(lock_level), .remote_selftest_in(selftest_level), .link_coding_err(err_pulse[2]),
    .ctrl_chan_seq_err(err_pulse[1]), .ctrl_chan_crc_err(err_pulse[0]), .gpio_output_mode(gpio_output_mode),
    .gpio_pulldown_en(gpio_pulldown_en), .eq_setting(eq_setting), .rx_lock(rx_lock), .port_irq(port_irq));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic t_reset;
    logic [7:0] addrs [8] = '{ADDR_PULLDOWN, ADDR_DEBUG, ADDR_EQ_TEST, ADDR_EQ_BYPASS, ADDR_EQ_LIMITS,
                              ADDR_IRQ_EN_HI, ADDR_IRQ_EN_LO, 8'hE0};
    logic [7:0] exps [8] = '{8'h00, 8'h00, 8'h80, 8'h60, 8'hF8, 8'h00, 8'h00, 8'h00};
    chk("pull-down", {3'h0, gpio_pulldown_en}, 8'h1F);
    for (int i = 0; i < 8; i++) begin
      rd(addrs[i], rv);
      chk("reset value", rv, exps[i]);
    end
  endtask : t_reset
  task automatic t_pulldown;
    @(posedge clk_sys);
    gpio_output_mode <= 5'h03;
    wr(ADDR_PULLDOWN, 8'h05);
    cyc(2);
    chk("pull-down", {3'h0, gpio_pulldown_en}, 8'h18);
    // A write while the clock enable is low must be lost
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(ADDR_PULLDOWN, 8'h00);
    @(posedge clk_sys);
    ce <= 1'b1;
    rd(ADDR_PULLDOWN, rv);
    chk("frozen write", rv, 8'h05);
  endtask : t_pulldown
  task automatic t_selftest;
    @(posedge clk_sys);
    bist_cmd <= 1'b1;
    wr(ADDR_DEBUG, 8'hFF);
    cyc(4);
    rd(ADDR_DEBUG, rv);
    chk("debug byte", rv, 8'h7F);
    @(posedge clk_sys);
    bist_cmd <= 1'b0;
    cyc(4);
    rd(ADDR_DEBUG, rv);
    chk("debug byte", rv, DBG_RW_MASK);
  endtask : t_selftest
  task automatic t_irq;
    logic [7:0] sts [3] = '{ADDR_PORT_STS1, ADDR_PORT_STS1, ADDR_PORT_STS2};
    wr(ADDR_IRQ_EN_HI, 8'hFF);
    rd(ADDR_IRQ_EN_HI, rv);
    chk("enable byte", rv, 8'h07);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_IRQ_EN_HI, 8'h00);
      @(posedge clk_sys);
      err_cmd <= 3'(1 << i);
      @(posedge clk_sys);
      err_cmd <= 3'h0;
      cyc(4);
      chk("masked irq", {7'h0, port_irq}, 8'h00);
      rd(ADDR_IRQ_STS_HI, rv);
      chk("latched", rv, 8'(1 << i));
      wr(ADDR_IRQ_EN_HI, 8'(1 << i));
      cyc(3);
      chk("enabled irq", {7'h0, port_irq}, 8'h01);
      rd(sts[i], rv);
      chk("status", rv, (i == 2) ? 8'h01 : 8'(1 << i));
      cyc(3);
      chk("cleared irq", {7'h0, port_irq}, 8'h00);
    end
  endtask : t_irq
  task automatic t_bypass;
    wr(ADDR_EQ_BYPASS, 8'hA5);
    cyc(3);
    chk("manual setting", {2'b00, eq_setting}, 8'h2A);
    rd(ADDR_EQ_STATUS, rv);
    chk("eq status", rv, 8'h2A);
  endtask : t_bypass
  task automatic next_step(output int iv);
    logic [5:0] old;
    old = eq_setting;
    iv = 0;
    while (eq_setting === old && iv < 1000) begin
      @(posedge clk_sys);
      #1;
      iv++;
    end
  endtask : next_step
  task automatic t_adapt;
    logic [7:0] steps [4] = '{8'h03, 8'h04, 8'h05, 8'h02};
    int         iv0;
    int         iv1;
    wr(ADDR_EQ_LIMITS, 8'h52);
    wr(ADDR_EQ_TEST, 8'h04);
    wr(ADDR_EQ_BYPASS, 8'h00);
    wr(ADDR_EQ_TEST, 8'h0C);
    rd(ADDR_EQ_TEST, rv);
    chk("restart cleared", rv, 8'h04);
    cyc(2);
    chk("start", {2'b00, eq_setting}, 8'h02);
    for (int i = 0; i < 4; i++) begin
      next_step(iv0);
      chk("step", {2'b00, eq_setting}, steps[i]);
    end
    wr(ADDR_EQ_TEST, 8'h34);
    next_step(iv1);
    next_step(iv1);
    chk("relock wait", 8'(iv1 - iv0), 8'(BASE));
    wr(ADDR_EQ_BYPASS, 8'h10);
    @(posedge clk_sys);
    lock_cmd <= 1'b1;
    cyc(4);
    chk("lock waits", {7'h0, rx_lock}, 8'h00);
    cyc(2);
    chk("lock", {7'h0, rx_lock}, 8'h01);
    chk("first lock", {2'b00, eq_setting}, 8'h00);
    rv = {2'b00, eq_setting};
    cyc(40);
    chk("held", {2'b00, eq_setting}, rv);
  endtask : t_adapt
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_pulldown();
    t_selftest();
    t_irq();
    t_bypass();
    t_adapt();
    summarize();
  end
endmodule : testbench
bind rxpeq_regs rxpeq_monitor #(.RELOCK_BASE(RELOCK_BASE), .NUM_GPIO(NUM_GPIO)) u_mon (.clk_sys(clk_sys),
  .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .lock_detect_in(lock_detect_in), .remote_selftest_in(remote_selftest_in),
  .link_coding_err(link_coding_err), .ctrl_chan_seq_err(ctrl_chan_seq_err),
  .ctrl_chan_crc_err(ctrl_chan_crc_err), .gpio_output_mode(gpio_output_mode),
  .gpio_pulldown_en(gpio_pulldown_en), .eq_setting(eq_setting), .rx_lock(rx_lock), .port_irq(port_irq));
